// ### logic/jrpb_params.svh
// constants of the scan-to-register-port bridge
// assumes inclusion by bare name from every design file that needs it
`ifndef JRPB_PARAMS_SVH
`define JRPB_PARAMS_SVH

// ----------------------------------------------------------------------
// instruction register
// ----------------------------------------------------------------------
`define JRPB_IR_LEN 10
`define JRPB_MON_INSTR 10'h3f7
`define JRPB_IR_CAPTURE 10'h001
`define JRPB_IR_RESET 10'h3ff

// ----------------------------------------------------------------------
// monitor scan register and command word layout
// ----------------------------------------------------------------------
`define JRPB_DR_LEN 32
`define JRPB_DATA_MSB 15
`define JRPB_DATA_LSB 0
`define JRPB_ADDR_MSB 25
`define JRPB_ADDR_LSB 16
`define JRPB_CMD_MSB 29
`define JRPB_CMD_LSB 26
`define JRPB_UPPER_ZERO 16'h0000
`define JRPB_HELD_RESET 16'h0000

// ----------------------------------------------------------------------
// command codes
// ----------------------------------------------------------------------
`define JRPB_CMD_NOP 4'h0
`define JRPB_CMD_READ 4'h1
`define JRPB_CMD_WRITE 4'h2

`endif

// ### logic/jrpb_pkg.sv
// types shared by the scan-to-register-port bridge
// assumes nothing beyond a SystemVerilog compiler
package jrpb_pkg;

    // ------------------------------------------------------------------
    // data and address carried on the register port, and the scan command field
    // ------------------------------------------------------------------
    typedef logic [15:0] jrpb_data_t;
    typedef logic [9:0] jrpb_addr_t;
    typedef logic [3:0] jrpb_cmd_t;

    // ------------------------------------------------------------------
    // test access port controller states
    // ------------------------------------------------------------------
    typedef enum logic [3:0] {
        TAP_RESET, TAP_IDLE,
        TAP_SEL_DR, TAP_CAP_DR, TAP_SHIFT_DR, TAP_EXIT1_DR,
        TAP_PAUSE_DR, TAP_EXIT2_DR, TAP_UPD_DR,
        TAP_SEL_IR, TAP_CAP_IR, TAP_SHIFT_IR, TAP_EXIT1_IR,
        TAP_PAUSE_IR, TAP_EXIT2_IR, TAP_UPD_IR
    } jrpb_tap_e;

    // ------------------------------------------------------------------
    // arbitrator states
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        ARB_IDLE, ARB_FABRIC, ARB_SCAN
    } jrpb_arb_e;

endpackage : jrpb_pkg

// ### logic/jrpb_sync.sv
// two-flop synchroniser for a bundle of unrelated level inputs
// assumes the inputs are asynchronous to clk; bits are not coherent
module jrpb_sync #(
    parameter int WIDTH = 1
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta;

    if (WIDTH < 1)
    begin : g_check
        $error("jrpb_sync needs WIDTH of at least 1");
    end

    // first stage feeds the second and nothing else
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            meta <= '0;
            sync_out <= '0;
        end
        else
        begin
            meta <= async_in;
            sync_out <= meta;
        end
    end
endmodule : jrpb_sync

// ### logic/jrpb_bridge.sv
// scan port to register port bridge with fabric arbitration
// assumes ref_clk is the port clock; tck/tms/tdi come from off chip
//
// How it works
// - instruction 1111110111 in the 10-bit register selects the monitor scan
// - the monitor scan register is fixed at 32 bits
// - the scan path is built in; no user primitive is needed
// - while that instruction holds, every data scan uses the monitor register
// - update hands the whole word to the arbitrator for the port access
// - a write is strobed onto a free port within six port clocks, then waits for port ready
// - capture loads the data the arbitrator holds now
// - captured word leaves on tdo lsb first while the next enters
// - low 16 bits carry port data, high 16 bits read zero
// - a read takes two scans; the result is held after the port read
// - held read result is captured in the next data scan
// - a scan starting before the read ends captures the stale data
// - reads pipeline: next read command shifts in with the last result
// - command word: data 15:0, address 25:16, command 29:26
// - command 0 no operation, 1 read, 2 write
// - neither a fabric nor a scan access interrupts the other
`include "jrpb_params.svh"

module jrpb_bridge #(
    parameter int IR_LEN = `JRPB_IR_LEN,
    parameter int DR_LEN = `JRPB_DR_LEN
) (
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic tck,
    input wire logic tms,
    input wire logic tdi,
    output logic tdo,
    output logic tdo_en,
    output logic port_en,
    output logic port_we,
    output jrpb_pkg::jrpb_addr_t port_addr,
    output jrpb_pkg::jrpb_data_t port_wdata,
    input wire jrpb_pkg::jrpb_data_t port_rdata,
    input wire logic port_rdy,
    input wire logic fab_en,
    input wire logic fab_we,
    input wire jrpb_pkg::jrpb_addr_t fab_addr,
    input wire jrpb_pkg::jrpb_data_t fab_wdata,
    output jrpb_pkg::jrpb_data_t fab_rdata,
    output logic fab_rdy,
    output logic jtag_busy
);
    import jrpb_pkg::*;

    // ------------------------------------------------------------------
    // elaboration checks
    // ------------------------------------------------------------------
    if (IR_LEN != `JRPB_IR_LEN)
    begin : g_ir_check
        $error("instruction length must match the monitor instruction");
    end
    if (DR_LEN != `JRPB_DR_LEN)
    begin : g_dr_check
        $error("monitor scan register length is fixed");
    end

    // ------------------------------------------------------------------
    // pin sampling and tck edge detection
    // ------------------------------------------------------------------
    logic tck_s, tms_s, tdi_s, tck_d;
    logic tck_rise, tck_fall;

    jrpb_sync #(.WIDTH(3)) u_sync (
        .clk(ref_clk),
        .reset(reset),
        .async_in({tck, tms, tdi}),
        .sync_out({tck_s, tms_s, tdi_s})
    );

    // tck is oversampled; it must stay well below half of ref_clk
    always_ff @(posedge ref_clk)
    begin
        if (reset)
            tck_d <= 1'b0;
        else
            tck_d <= tck_s;
    end

    assign tck_rise = tck_s & ~tck_d;
    assign tck_fall = ~tck_s & tck_d;

    // ------------------------------------------------------------------
    // tap controller
    // ------------------------------------------------------------------
    jrpb_tap_e tap, next_tap;

    always_comb
    begin
        unique case (tap)
            TAP_RESET: next_tap = tms_s ? TAP_RESET : TAP_IDLE;
            TAP_IDLE: next_tap = tms_s ? TAP_SEL_DR : TAP_IDLE;
            TAP_SEL_DR: next_tap = tms_s ? TAP_SEL_IR : TAP_CAP_DR;
            TAP_CAP_DR: next_tap = tms_s ? TAP_EXIT1_DR : TAP_SHIFT_DR;
            TAP_SHIFT_DR: next_tap = tms_s ? TAP_EXIT1_DR : TAP_SHIFT_DR;
            TAP_EXIT1_DR: next_tap = tms_s ? TAP_UPD_DR : TAP_PAUSE_DR;
            TAP_PAUSE_DR: next_tap = tms_s ? TAP_EXIT2_DR : TAP_PAUSE_DR;
            TAP_EXIT2_DR: next_tap = tms_s ? TAP_UPD_DR : TAP_SHIFT_DR;
            TAP_UPD_DR: next_tap = tms_s ? TAP_SEL_DR : TAP_IDLE;
            TAP_SEL_IR: next_tap = tms_s ? TAP_RESET : TAP_CAP_IR;
            TAP_CAP_IR: next_tap = tms_s ? TAP_EXIT1_IR : TAP_SHIFT_IR;
            TAP_SHIFT_IR: next_tap = tms_s ? TAP_EXIT1_IR : TAP_SHIFT_IR;
            TAP_EXIT1_IR: next_tap = tms_s ? TAP_UPD_IR : TAP_PAUSE_IR;
            TAP_PAUSE_IR: next_tap = tms_s ? TAP_EXIT2_IR : TAP_PAUSE_IR;
            TAP_EXIT2_IR: next_tap = tms_s ? TAP_UPD_IR : TAP_SHIFT_IR;
            TAP_UPD_IR: next_tap = tms_s ? TAP_SEL_DR : TAP_IDLE;
        endcase
    end

    // state advances on each sampled tck rising edge
    always_ff @(posedge ref_clk)
    begin
        if (reset)
            tap <= TAP_RESET;
        else if (tck_rise)
            tap <= next_tap;
    end

    // ------------------------------------------------------------------
    // instruction register
    // ------------------------------------------------------------------
    logic [IR_LEN-1:0] ir_shift, ir;
    logic mon_sel;

    // the monitor path is hard wired; no user primitive is involved
    assign mon_sel = (ir == `JRPB_MON_INSTR);

    always_ff @(posedge ref_clk)
    begin
        if (reset)
        begin
            ir_shift <= `JRPB_IR_CAPTURE;
            ir <= `JRPB_IR_RESET;
        end
        else if (tck_rise)
        begin
            unique case (tap)
                TAP_RESET: ir <= `JRPB_IR_RESET;
                TAP_CAP_IR: ir_shift <= `JRPB_IR_CAPTURE;
                TAP_SHIFT_IR: ir_shift <= {tdi_s, ir_shift[IR_LEN-1:1]};
                default: ;
            endcase
        end
        else if (tck_fall && tap == TAP_UPD_IR)
            ir <= ir_shift;
    end

    // ------------------------------------------------------------------
    // data registers: monitor scan register and bypass bit
    // ------------------------------------------------------------------
    logic [DR_LEN-1:0] dr;
    logic bypass;
    jrpb_data_t held;
    logic upd_pulse;

    // other instructions fall back to a one-bit bypass path
    always_ff @(posedge ref_clk)
    begin
        if (reset)
        begin
            dr <= '0;
            bypass <= 1'b0;
        end
        else if (tck_rise && mon_sel)
        begin
            if (tap == TAP_CAP_DR)
                dr <= {`JRPB_UPPER_ZERO, held};
            else if (tap == TAP_SHIFT_DR)
                dr <= {tdi_s, dr[DR_LEN-1:1]};
        end
        else if (tck_rise)
        begin
            if (tap == TAP_CAP_DR)
                bypass <= 1'b0;
            else if (tap == TAP_SHIFT_DR)
                bypass <= tdi_s;
        end
    end

    // whole word goes to the arbitrator in update-dr
    assign upd_pulse = tck_fall && tap == TAP_UPD_DR && mon_sel;

    // tdo changes on the falling tck edge, lsb first
    always_ff @(posedge ref_clk)
    begin
        if (reset)
        begin
            tdo <= 1'b0;
            tdo_en <= 1'b0;
        end
        else if (tck_fall)
        begin
            tdo_en <= (tap == TAP_SHIFT_DR) || (tap == TAP_SHIFT_IR);
            if (tap == TAP_SHIFT_IR)
                tdo <= ir_shift[0];
            else if (mon_sel)
                tdo <= dr[0];
            else
                tdo <= bypass;
        end
    end

    // ------------------------------------------------------------------
    // pending requests from both sides
    // ------------------------------------------------------------------
    logic scan_pend, scan_we, fab_pend, fab_pend_we;
    jrpb_addr_t scan_addr, fab_pend_addr;
    jrpb_data_t scan_data, fab_pend_data;
    jrpb_cmd_t cmd;
    jrpb_arb_e arb;
    logic issue_fab, issue_scan, cmd_valid;
    // direction of the scan access on the port; scan_we may move meanwhile
    logic arb_we;

    assign cmd = dr[`JRPB_CMD_MSB:`JRPB_CMD_LSB];
    assign cmd_valid = (cmd == `JRPB_CMD_READ) || (cmd == `JRPB_CMD_WRITE);
    assign issue_fab = (arb == ARB_IDLE) && fab_pend;
    assign issue_scan = (arb == ARB_IDLE) && !fab_pend && scan_pend;

    // scan command latch; a new update wins over the issue clear
    always_ff @(posedge ref_clk)
    begin
        if (reset)
        begin
            scan_pend <= 1'b0;
            scan_we <= 1'b0;
            scan_addr <= '0;
            scan_data <= '0;
        end
        else if (upd_pulse && cmd_valid)
        begin
            scan_pend <= 1'b1;
            scan_we <= (cmd == `JRPB_CMD_WRITE);
            scan_addr <= dr[`JRPB_ADDR_MSB:`JRPB_ADDR_LSB];
            scan_data <= dr[`JRPB_DATA_MSB:`JRPB_DATA_LSB];
        end
        else if (issue_scan)
            scan_pend <= 1'b0;
    end

    // fabric request is queued while a scan access owns the port
    always_ff @(posedge ref_clk)
    begin
        if (reset)
        begin
            fab_pend <= 1'b0;
            fab_pend_we <= 1'b0;
            fab_pend_addr <= '0;
            fab_pend_data <= '0;
        end
        else if (fab_en)
        begin
            fab_pend <= 1'b1;
            fab_pend_we <= fab_we;
            fab_pend_addr <= fab_addr;
            fab_pend_data <= fab_wdata;
        end
        else if (issue_fab)
            fab_pend <= 1'b0;
    end

    // ------------------------------------------------------------------
    // arbitrator: one transaction at a time on the register port
    // ------------------------------------------------------------------
    always_ff @(posedge ref_clk)
    begin
        if (reset)
        begin
            arb <= ARB_IDLE;
            port_en <= 1'b0;
            port_we <= 1'b0;
            port_addr <= '0;
            port_wdata <= '0;
            fab_rdy <= 1'b0;
            fab_rdata <= '0;
            held <= `JRPB_HELD_RESET;
            arb_we <= 1'b0;
        end
        else
        begin
            port_en <= 1'b0;
            port_we <= 1'b0;
            fab_rdy <= 1'b0;
            unique case (arb)
                ARB_IDLE:
                    if (issue_fab)
                    begin
                        arb <= ARB_FABRIC;
                        port_en <= 1'b1;
                        port_we <= fab_pend_we;
                        port_addr <= fab_pend_addr;
                        port_wdata <= fab_pend_data;
                    end
                    else if (issue_scan)
                    begin
                        arb <= ARB_SCAN;
                        port_en <= 1'b1;
                        port_we <= scan_we;
                        arb_we <= scan_we;
                        port_addr <= scan_addr;
                        port_wdata <= scan_data;
                    end
                ARB_FABRIC:
                    if (port_rdy)
                    begin
                        arb <= ARB_IDLE;
                        fab_rdy <= 1'b1;
                        fab_rdata <= port_rdata;
                    end
                ARB_SCAN:
                    if (port_rdy)
                    begin
                        arb <= ARB_IDLE;
                        // issued fields, so a pipelined update cannot leak in
                        held <= arb_we ? port_wdata : port_rdata;
                    end
            endcase
        end
    end

    // busy from update until the scan transaction ends
    always_ff @(posedge ref_clk)
    begin
        if (reset)
            jtag_busy <= 1'b0;
        else
            jtag_busy <= (upd_pulse && cmd_valid) || scan_pend
                || (arb == ARB_SCAN && !port_rdy);
    end
endmodule : jrpb_bridge

// ### verif/jrpb_bridge_props.sv
// port checks for the scan to register port bridge
// assumes the bind below reaches every bridge instance
module jrpb_bridge_props import jrpb_pkg::*; (
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic port_en,
    input wire logic port_we,
    input wire jrpb_pkg::jrpb_addr_t port_addr,
    input wire jrpb_pkg::jrpb_data_t port_wdata,
    input wire jrpb_pkg::jrpb_data_t port_rdata,
    input wire logic port_rdy,
    input wire logic fab_en,
    input wire logic fab_we,
    input wire jrpb_pkg::jrpb_addr_t fab_addr,
    input wire jrpb_pkg::jrpb_data_t fab_rdata,
    input wire logic fab_rdy,
    input wire logic jtag_busy
);
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (reset);

    logic busy_port;
    logic fab_pend;
    logic fab_rd;

    // ------------------------------------------------------------
    // bookkeeping
    // ------------------------------------------------------------
    // open port access, from strobe to ready
    always_ff @(posedge ref_clk)
    begin
        if (reset)
            busy_port <= 1'b0;
        else if (port_en)
            busy_port <= 1'b1;
        else if (port_rdy)
            busy_port <= 1'b0;
    end

    // open fabric request; direction kept for the data check
    always_ff @(posedge ref_clk)
    begin
        if (reset)
            fab_pend <= 1'b0;
        else if (fab_en)
            fab_pend <= 1'b1;
        else if (fab_rdy)
            fab_pend <= 1'b0;
        if (fab_en)
            fab_rd <= !fab_we;
    end

    sequence s_fab_req;
        fab_en && !busy_port && !jtag_busy;
    endsequence
    sequence s_fab_issue;
        port_en && port_we == $past(fab_we, 2)
            && port_addr == $past(fab_addr, 2);
    endsequence

    chk_one_open: assert property (busy_port |-> !port_en)
        else $error("port strobe before previous ready");
    chk_we_qualified: assert property (port_we |-> port_en)
        else $error("write qualifier without strobe");
    chk_fields_hold: assert property (busy_port |->
        $stable(port_addr) && $stable(port_wdata))
        else $error("port fields moved during access");
    chk_scan_bound: assert property (
        $rose(jtag_busy) && !busy_port |-> ##[0:6] port_en)
        else $error("scan access not issued in time");
    chk_busy_hold: assert property ($fell(jtag_busy) |->
        $past(port_rdy) || $past(port_rdy, 2))
        else $error("scan busy dropped before port ready");
    chk_fab_first: assert property (s_fab_req |=> ##1 s_fab_issue)
        else $error("idle fabric request not issued next");
    chk_fab_done: assert property (fab_rdy |->
        fab_pend && $past(port_rdy))
        else $error("fabric ready without its port access");
    chk_fab_data: assert property (fab_rdy && fab_rd |->
        fab_rdata == $past(port_rdata))
        else $error("fabric read data differs from port");
endmodule : jrpb_bridge_props

bind jrpb_bridge jrpb_bridge_props jrpb_bridge_props_i (
    .ref_clk, .reset, .port_en, .port_we, .port_addr, .port_wdata,
    .port_rdata, .port_rdy, .fab_en, .fab_we, .fab_addr, .fab_rdata,
    .fab_rdy, .jtag_busy
);

// ### verif/jrpb_jtag_host.sv
// scan host model: drives tck, tms and tdi, reads tdo
// assumes clk is the bench clock; one tck period is 8 clk periods
module jrpb_jtag_host (
    input wire logic clk,
    input wire logic tdo,
    output logic tck,
    output logic tms,
    output logic tdi
);
    timeunit 1ns;
    timeprecision 1ps;

    // tck low at reset release; it stands still between frames
    initial
    begin
        tck = 1'b0;
        tms = 1'b1;
        tdi = 1'b0;
    end

    // one tck period; tdo read late in the high half where it is settled
    task automatic bit_io(input logic m, input logic d, output logic o);
        tck = 1'b0;
        tms = m;
        tdi = d;
        repeat (4) @(negedge clk);
        tck = 1'b1;
        repeat (4) @(negedge clk);
        o = tdo;
    endtask : bit_io

    // walk the controller by a tms pattern, lsb first
    task automatic walk(input logic [7:0] pat, input int n);
        logic o;
        for (int i = 0; i < n; i++)
            bit_io(pat[i], 1'b0, o);
    endtask : walk

    // load an instruction, ending in run-test-idle
    task automatic load_ir(input logic [9:0] ir);
        logic o;
        walk(8'h06, 5);
        for (int i = 0; i < 10; i++)
            bit_io(i == 9, ir[i], o);
        walk(8'h01, 2);
    endtask : load_ir

    // one command scan; captured bits come back in got
    task automatic dr_scan(input logic [31:0] cmd, input int idles,
                           output logic [31:0] got);
        walk(8'h01, 3);
        for (int i = 0; i < 32; i++)
            bit_io(i == 31, cmd[i], got[i]);
        walk(8'h01, 1);
        walk(8'h00, idles);
    endtask : dr_scan
endmodule : jrpb_jtag_host

// ### verif/jrpb_bridge_tb.sv
// self-checking bench for the scan to register port bridge
// assumes the host model and a register port model in this module
`include "jrpb_params.svh"
module jrpb_bridge_tb;
    timeunit 1ns;
    timeprecision 1ps;

    logic ref_clk = 1'b0;
    logic reset = 1'b1;
    logic tck, tms, tdi, tdo, tdo_en, port_en, port_we, jtag_busy;
    logic port_rdy = 1'b0;
    logic fab_en = 1'b0;
    logic fab_we = 1'b0;
    logic fab_rdy;
    logic s_we;
    jrpb_pkg::jrpb_addr_t port_addr, s_addr;
    jrpb_pkg::jrpb_addr_t fab_addr = 10'h000;
    jrpb_pkg::jrpb_data_t port_wdata, fab_rdata, s_wd;
    jrpb_pkg::jrpb_data_t port_rdata = 16'h0000;
    jrpb_pkg::jrpb_data_t fab_wdata = 16'h0000;
    jrpb_pkg::jrpb_data_t mem [1024];
    logic [31:0] got;
    int lat = 1;
    int s_cnt = 0;
    int n_port = 0;
    int n_mismatch = 0;
    int cmp_count = 0;

    always #12.5 ref_clk = ~ref_clk;

    jrpb_bridge jrpb_bridge_i (
        .ref_clk, .reset, .tck, .tms, .tdi, .tdo, .tdo_en,
        .port_en, .port_we, .port_addr, .port_wdata, .port_rdata,
        .port_rdy, .fab_en, .fab_we, .fab_addr, .fab_wdata, .fab_rdata,
        .fab_rdy, .jtag_busy
    );
    jrpb_jtag_host jrpb_jtag_host_i (.clk(ref_clk), .tdo, .tck, .tms, .tdi);

    // register port model; read data scrambled outside the answer cycle
    always @(posedge ref_clk)
    begin
        port_rdy <= 1'b0;
        port_rdata <= ~port_rdata;
        if (port_en)
        begin
            n_port <= n_port + 1;
            s_cnt <= lat;
            s_we <= port_we;
            s_addr <= port_addr;
            s_wd <= port_wdata;
        end
        else if (s_cnt == 1)
        begin
            s_cnt <= 0;
            port_rdy <= 1'b1;
            if (s_we)
                mem[s_addr] <= s_wd;
            else
                port_rdata <= mem[s_addr];
        end
        else if (s_cnt > 1)
            s_cnt <= s_cnt - 1;
    end

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] mk(input logic [3:0] c,
                                       input logic [9:0] a,
                                       input logic [15:0] d);
        return {2'b00, c, a, d};
    endfunction : mk

    task automatic report_and_stop();
        $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : report_and_stop

    task automatic chk(input string what, input logic [31:0] exp,
                       input logic [31:0] seen);
        cmp_count++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    // one fabric access; a missing ready ends the run
    task automatic fab_op(input logic we, input logic [9:0] a,
                          input logic [15:0] d);
        fab_en = 1'b1;
        fab_we = we;
        fab_addr = a;
        fab_wdata = d;
        @(negedge ref_clk);
        fab_en = 1'b0;
        for (int i = 0; i < 300 && fab_rdy !== 1'b1; i++)
            @(negedge ref_clk);
        if (fab_rdy !== 1'b1)
        begin
            n_mismatch++;
            report_and_stop();
        end
    endtask : fab_op

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    // before the monitor instruction a data scan reaches no port
    task automatic t_bypass();
        jrpb_jtag_host_i.walk(8'h00, 1);
        jrpb_jtag_host_i.dr_scan(mk(`JRPB_CMD_WRITE, 10'h2a, 16'h1111), 2,
                                 got);
        chk("bypass port count", 0, n_port);
        jrpb_jtag_host_i.load_ir(`JRPB_MON_INSTR);
    endtask : t_bypass

    task automatic t_write();
        // tdo_en stands only during shift, so it is watched mid-scan
        fork
            jrpb_jtag_host_i.dr_scan(
                mk(`JRPB_CMD_WRITE, 10'h2a, 16'hbeef), 12, got);
            begin
                for (int i = 0; i < 400 && tdo_en !== 1'b1; i++)
                    @(negedge ref_clk);
                chk("shift enable", 1, tdo_en);
                if (tdo_en !== 1'b1)
                    report_and_stop();
            end
        join
        chk("reset capture", 32'h0, got);
        chk("port write", 16'hbeef, mem[10'h2a]);
        chk("shift idle", 0, tdo_en);
        jrpb_jtag_host_i.dr_scan(mk(`JRPB_CMD_NOP, 10'h0, 16'h0), 12, got);
        chk("write capture", {16'h0, 16'hbeef}, got);
    endtask : t_write

    // fabric fills two places, then two pipelined scan reads
    task automatic t_read_pipe();
        fab_op(1'b1, 10'h005, 16'h1234);
        fab_op(1'b1, 10'h006, 16'h5678);
        fab_op(1'b0, 10'h005, 16'h0000);
        chk("fabric read", 16'h1234, fab_rdata);
        jrpb_jtag_host_i.dr_scan(mk(`JRPB_CMD_READ, 10'h5, 16'h0), 12, got);
        chk("nop keeps held", {16'h0, 16'hbeef}, got);
        jrpb_jtag_host_i.dr_scan(mk(`JRPB_CMD_READ, 10'h6, 16'h0), 12, got);
        chk("first read", {16'h0, 16'h1234}, got);
        jrpb_jtag_host_i.dr_scan(mk(`JRPB_CMD_NOP, 10'h0, 16'h0), 12, got);
        chk("second read", {16'h0, 16'h5678}, got);
    endtask : t_read_pipe

    // slow port and no idle: the next capture sees old data
    task automatic t_stale();
        lat = 40;
        jrpb_jtag_host_i.dr_scan(mk(`JRPB_CMD_READ, 10'h2a, 16'h0), 0, got);
        jrpb_jtag_host_i.dr_scan(mk(`JRPB_CMD_NOP, 10'h0, 16'h0), 12, got);
        chk("stale capture", {16'h0, 16'h5678}, got);
        jrpb_jtag_host_i.dr_scan(mk(`JRPB_CMD_NOP, 10'h0, 16'h0), 12, got);
        chk("late capture", {16'h0, 16'hbeef}, got);
        lat = 1;
    endtask : t_stale

    // every code but read and write leaves port and held data alone
    task automatic t_undef();
        int n0;
        for (int c = 0; c < 16; c++)
        begin
            if (c == 1 || c == 2)
                continue;
            n0 = n_port;
            jrpb_jtag_host_i.dr_scan(mk(c[3:0], 10'h2a, 16'h0bad), 12, got);
            chk("undefined port count", n0, n_port);
            chk("undefined capture", {16'h0, 16'hbeef}, got);
        end
        chk("undefined write", 16'hbeef, mem[10'h2a]);
    endtask : t_undef

    // fabric read during a scan write waits and sees the new value
    task automatic t_collide();
        lat = 3;
        fork
            jrpb_jtag_host_i.dr_scan(mk(`JRPB_CMD_WRITE, 10'h33, 16'h4321),
                                     12, got);
            begin
                for (int i = 0; i < 2000 && jtag_busy !== 1'b1; i++)
                    @(negedge ref_clk);
                // a busy flag that never rises ends the run
                if (jtag_busy !== 1'b1)
                begin
                    n_mismatch++;
                    report_and_stop();
                end
                fab_op(1'b0, 10'h033, 16'h0000);
                chk("queued fabric read", 16'h4321, fab_rdata);
            end
        join
        lat = 1;
    endtask : t_collide

    // reset for 5 cycles, then the scenarios in order
    initial
    begin
        repeat (5) @(negedge ref_clk);
        reset = 1'b0;
        repeat (4) @(negedge ref_clk);
        t_bypass();
        t_write();
        t_read_pipe();
        t_stale();
        t_undef();
        t_collide();
        report_and_stop();
    end
endmodule : jrpb_bridge_tb
